/* File: hw/sec_host.sv */
// Operation
// - opcode 06h sets latch, 04h clears
// - 05h reads status, 01h writes status
// - array read/write opcodes carry address bit eight
// - data sampled rising, output changes falling
// - every command begins with select falling
// - programming starts on select rising
// - pause and resume only while clock low
// - pause pin high when unused
// - latch set needs deselect first
// - byte write: opcode, address, data, deselect
//
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`include "sec_regs.svh"

module sec_host
   import sec_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic spi_cs_n,
   output logic spi_sck,
   output logic spi_mosi,
   output logic spi_hold_n,
   output logic spi_wp_n,
   input wire logic spi_miso
);

   sec_cmd_t cmd_kind;
   sec_cmd_t eff_kind;
   sec_state_t state;
   logic [8:0] addr_reg;
   logic [4:0] count_reg;
   logic pause_req;
   logic running;
   logic dev_busy;
   logic refused;
   logic poll;
   logic [7:0] last_status;
   logic [7:0] page_mem [0:15];
   logic [4:0] byte_idx;
   logic [4:0] nbytes;
   logic [3:0] gap_cnt;
   logic [3:0] data_idx;
   logic [7:0] tx_byte;
   logic shift_start;
   logic shift_done;
   logic [7:0] shift_rx;
   logic tick;
   sec_shift_out_t shift_pins;
   logic acc_write;
   logic launch;
   logic bad_launch;
   logic [8:0] prot_base;
   logic is_write_cmd;

   assign acc_write = avs_write && !avs_waitrequest;

   // ==========================================================
   // helpers
   sec_tick_div u_div (
      .clock(clock),
      .rst(rst),
      .tick(tick)
   );

   sec_spi_shift u_shift (
      .clock(clock),
      .rst(rst),
      .tick(tick),
      .start(shift_start),
      .tx_byte(tx_byte),
      .pause(pause_req),
      .miso(spi_miso),
      .pins(shift_pins),
      .done(shift_done),
      .rx_byte(shift_rx)
   );

   assign spi_sck = shift_pins.sck;
   assign spi_mosi = shift_pins.mosi;
   assign spi_hold_n = shift_pins.hold_n;

   // ==========================================================
   // command decode
   always_comb begin
      eff_kind = poll ? cmd_status_read : cmd_kind;
      data_idx = 4'(byte_idx - 5'h2);
      is_write_cmd = (cmd_kind == cmd_array_write) || (cmd_kind == cmd_status_write);
      case (eff_kind)
         cmd_latch_set: nbytes = 5'h1;
         cmd_latch_clear: nbytes = 5'h1;
         cmd_status_read: nbytes = 5'h2;
         cmd_status_write: nbytes = 5'h2;
         default: nbytes = count_reg + 5'h2;
      endcase
   end

   always_comb begin
      tx_byte = 8'h00;
      if (byte_idx == 5'h0) begin
         case (eff_kind)
            cmd_latch_set: tx_byte = `SEC_OP_LATCH_SET;
            cmd_latch_clear: tx_byte = `SEC_OP_LATCH_CLR;
            cmd_status_read: tx_byte = `SEC_OP_STAT_RD;
            cmd_status_write: tx_byte = `SEC_OP_STAT_WR;
            cmd_array_read: tx_byte = {`SEC_OP_ZERO_HI, addr_reg[8], `SEC_OP_ARR_RD_LO};
            cmd_array_write: tx_byte = {`SEC_OP_ZERO_HI, addr_reg[8], `SEC_OP_ARR_WR_LO};
            default: tx_byte = `SEC_OP_STAT_RD;
         endcase
      end else if (byte_idx == 5'h1) begin
         case (eff_kind)
            cmd_status_write: tx_byte = {4'h0, page_mem[0][3:2], 2'b00};
            cmd_array_read: tx_byte = addr_reg[7:0];
            cmd_array_write: tx_byte = addr_reg[7:0];
            default: tx_byte = 8'h00;
         endcase
      end else if (eff_kind == cmd_array_write) begin
         tx_byte = page_mem[data_idx];
      end
   end

   // ==========================================================
   // protection check against last known status
   always_comb begin
      case (last_status[`SEC_DEV_BP_LSB +: 2])
         2'b01: prot_base = `SEC_PROT_QUARTER;
         2'b10: prot_base = `SEC_PROT_HALF;
         2'b11: prot_base = `SEC_PROT_FULL;
         default: prot_base = 9'h000;
      endcase
   end

   // a command is taken only when idle and its code is defined
   assign launch = acc_write && (avs_address == `SEC_OFS_CMD) && !running
      && (avs_writedata[2:0] <= 3'(cmd_array_write));
   // undefined codes never reach the pins
   assign bad_launch = acc_write && (avs_address == `SEC_OFS_CMD) && (running
      || (avs_writedata[2:0] > 3'(cmd_array_write))
      || ((3'(avs_writedata[2:0]) == 3'(cmd_array_write))
         && (last_status[`SEC_DEV_BP_LSB +: 2] != 2'b00)
         && ({addr_reg[8:4], 4'h0} >= prot_base)));

   // ==========================================================
   // avalon slave: one wait cycle on every access
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && avs_waitrequest) begin
         avs_readdata <= 32'h0000_0000;
         if (avs_address == `SEC_OFS_CMD) begin
            avs_readdata[2:0] <= cmd_kind;
         end else if (avs_address == `SEC_OFS_ADDR) begin
            avs_readdata[8:0] <= addr_reg;
         end else if (avs_address == `SEC_OFS_COUNT) begin
            avs_readdata[4:0] <= count_reg;
         end else if (avs_address == `SEC_OFS_PINS) begin
            avs_readdata[`SEC_PINS_INHIBIT] <= !spi_wp_n;
            avs_readdata[`SEC_PINS_PAUSE] <= pause_req;
         end else if (avs_address == `SEC_OFS_STAT) begin
            avs_readdata[`SEC_STAT_RUNNING] <= running;
            avs_readdata[`SEC_STAT_DEV_BUSY] <= dev_busy;
            avs_readdata[`SEC_STAT_REFUSED] <= refused;
            avs_readdata[`SEC_STAT_LAST_LSB +: 8] <= last_status;
         end else if (avs_address >= `SEC_OFS_DATA_LO && avs_address <= `SEC_OFS_DATA_HI) begin
            avs_readdata[7:0] <= page_mem[avs_address[5:2]];
         end
      end
   end

   // ==========================================================
   // configuration registers, refused while a command runs
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cmd_kind <= cmd_latch_set;
         addr_reg <= `SEC_RST_ADDR;
         count_reg <= `SEC_RST_COUNT;
      end else if (launch) begin
         cmd_kind <= sec_cmd_t'(avs_writedata[2:0]);
      end else if (acc_write && !running) begin
         if (avs_address == `SEC_OFS_ADDR) begin
            addr_reg <= avs_writedata[8:0];
         end
         if (avs_address == `SEC_OFS_COUNT) begin
            // page limited to sixteen bytes, zero taken as one
            if (avs_writedata[4:0] == 5'h0) begin
               count_reg <= 5'h1;
            end else if (avs_writedata[4:0] > `SEC_PAGE_BYTES) begin
               count_reg <= `SEC_PAGE_BYTES;
            end else begin
               count_reg <= avs_writedata[4:0];
            end
         end
      end
   end

   // pin controls stay writable at any time
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         spi_wp_n <= 1'b1;
         pause_req <= 1'b0;
      end else if (acc_write && avs_address == `SEC_OFS_PINS) begin
         spi_wp_n <= !avs_writedata[`SEC_PINS_INHIBIT];
         pause_req <= avs_writedata[`SEC_PINS_PAUSE];
      end
   end

   // sticky refusal flag, a new refusal wins over the clear
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         refused <= 1'b0;
      end else if (bad_launch) begin
         refused <= 1'b1;
      end else if (acc_write && avs_address == `SEC_OFS_STAT
         && avs_writedata[`SEC_STAT_REFUSED]) begin
         refused <= 1'b0;
      end
   end

   // ==========================================================
   // page buffer: software fills it, array reads land in it
   always_ff @(posedge clock) begin
      if (shift_done && eff_kind == cmd_array_read && byte_idx >= 5'h2) begin
         page_mem[data_idx] <= shift_rx;
      end else if (acc_write && !running && avs_address >= `SEC_OFS_DATA_LO
         && avs_address <= `SEC_OFS_DATA_HI) begin
         page_mem[avs_address[5:2]] <= avs_writedata[7:0];
      end
   end

   // ==========================================================
   // device status as last read back
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         last_status <= `SEC_RST_STATUS;
         dev_busy <= 1'b0;
      end else if (shift_done && eff_kind == cmd_status_read && byte_idx == 5'h1) begin
         last_status <= shift_rx;
         dev_busy <= shift_rx[`SEC_DEV_READY_BIT];
      end
   end

   // ==========================================================
   // frame sequencer
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= st_idle;
         spi_cs_n <= 1'b1;
         running <= 1'b0;
         poll <= 1'b0;
         byte_idx <= 5'h0;
         gap_cnt <= 4'h0;
         shift_start <= 1'b0;
      end else begin
         shift_start <= 1'b0;
         case (state)
            st_idle: begin
               if (launch) begin
                  running <= 1'b1;
                  poll <= 1'b0;
                  state <= st_setup;
                  gap_cnt <= 4'(`SEC_CS_GAP_CYC);
                  byte_idx <= 5'h0;
                  spi_cs_n <= 1'b0;
               end
            end
            st_setup: begin
               if (gap_cnt > 4'h1) begin
                  gap_cnt <= gap_cnt - 4'h1;
               end else begin
                  shift_start <= 1'b1;
                  state <= st_byte;
               end
            end
            st_byte: begin
               if (shift_done) begin
                  if (byte_idx + 5'h1 == nbytes) begin
                     state <= st_hold;
                     gap_cnt <= 4'(`SEC_CS_GAP_CYC);
                  end else begin
                     byte_idx <= byte_idx + 5'h1;
                     shift_start <= 1'b1;
                  end
               end
            end
            st_hold: begin
               if (gap_cnt > 4'h1) begin
                  gap_cnt <= gap_cnt - 4'h1;
               end else begin
                  // every command in its own frame
                  spi_cs_n <= 1'b1;
                  state <= st_desel;
                  gap_cnt <= 4'(`SEC_CS_GAP_CYC);
               end
            end
            st_desel: begin
               if (gap_cnt > 4'h1) begin
                  gap_cnt <= gap_cnt - 4'h1;
               end else if ((is_write_cmd && !poll) || (poll && dev_busy)) begin
                  poll <= 1'b1;
                  byte_idx <= 5'h0;
                  spi_cs_n <= 1'b0;
                  state <= st_setup;
                  gap_cnt <= 4'(`SEC_CS_GAP_CYC);
               end else begin
                  running <= 1'b0;
                  poll <= 1'b0;
                  state <= st_idle;
               end
            end
            default: begin
               state <= st_idle;
               spi_cs_n <= 1'b1;
               running <= 1'b0;
            end
         endcase
      end
   end

endmodule : sec_host

/* File: hw/sec_pkg.sv */
package sec_pkg;

   typedef enum logic [2:0] {
      cmd_latch_set,
      cmd_latch_clear,
      cmd_status_read,
      cmd_status_write,
      cmd_array_read,
      cmd_array_write
   } sec_cmd_t;

   typedef enum logic [2:0] {
      st_idle,
      st_setup,
      st_byte,
      st_hold,
      st_desel
   } sec_state_t;

   typedef struct packed {
      logic sck;
      logic mosi;
      logic hold_n;
   } sec_shift_out_t;

endpackage : sec_pkg

/* File: hw/sec_regs.svh */
`ifndef SEC_REGS_SVH
`define SEC_REGS_SVH

// ==========================================================
// register map (byte offsets on the avalon slave)
`define SEC_OFS_CMD 8'h00
`define SEC_OFS_ADDR 8'h04
`define SEC_OFS_COUNT 8'h08
`define SEC_OFS_PINS 8'h0C
`define SEC_OFS_STAT 8'h10
`define SEC_OFS_DATA_LO 8'h40
`define SEC_OFS_DATA_HI 8'h7C

// ==========================================================
// field positions
`define SEC_PINS_INHIBIT 0
`define SEC_PINS_PAUSE 1
`define SEC_STAT_RUNNING 0
`define SEC_STAT_DEV_BUSY 1
`define SEC_STAT_REFUSED 2
`define SEC_STAT_LAST_LSB 8
`define SEC_DEV_READY_BIT 0
`define SEC_DEV_WEL_BIT 1
`define SEC_DEV_BP_LSB 2

// ==========================================================
// reset values and page size
`define SEC_RST_ADDR 9'h000
`define SEC_RST_COUNT 5'h01
`define SEC_RST_STATUS 8'h00
`define SEC_PAGE_BYTES 5'h10

// ==========================================================
// device opcodes
`define SEC_OP_LATCH_SET 8'h06
`define SEC_OP_LATCH_CLR 8'h04
`define SEC_OP_STAT_RD 8'h05
`define SEC_OP_STAT_WR 8'h01
`define SEC_OP_ARR_RD_LO 3'h3
`define SEC_OP_ARR_WR_LO 3'h2
`define SEC_OP_ZERO_HI 4'h0

// ==========================================================
// protected range lower bounds, largest density
`define SEC_PROT_QUARTER 9'h180
`define SEC_PROT_HALF 9'h100
`define SEC_PROT_FULL 9'h000

// ==========================================================
// timing
`define SEC_CLK_NS 100
`define SEC_SCK_HALF_NS 200
`define SEC_SCK_HALF_CYC ((`SEC_SCK_HALF_NS + `SEC_CLK_NS - 1) / `SEC_CLK_NS)
`define SEC_CS_GAP_NS 50
`define SEC_CS_GAP_CYC ((`SEC_CS_GAP_NS + `SEC_CLK_NS - 1) / `SEC_CLK_NS)

`endif

/* File: hw/sec_spi_shift.sv */
`timescale 1ns/1ps
`include "sec_regs.svh"

module sec_spi_shift
   import sec_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic tick,
   input wire logic start,
   input wire logic [7:0] tx_byte,
   input wire logic pause,
   input wire logic miso,
   output sec_shift_out_t pins,
   output logic done,
   output logic [7:0] rx_byte
);

   logic miso_meta;
   logic miso_sync;
   logic active;
   logic [2:0] bit_cnt;
   logic [7:0] shreg;

   // ==========================================================
   // input synchroniser
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         miso_meta <= 1'b0;
         miso_sync <= 1'b0;
      end else begin
         miso_meta <= miso;
         miso_sync <= miso_meta;
      end
   end

   // ==========================================================
   // mode 0 shifter
   // sampling happens at the falling tick: the synchroniser lag of two
   // cycles then points back at the rising edge, so half period >= 2
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         active <= 1'b0;
         bit_cnt <= 3'h0;
         shreg <= 8'h00;
         rx_byte <= 8'h00;
         done <= 1'b0;
         pins <= '{sck: 1'b0, mosi: 1'b0, hold_n: 1'b1};
      end else begin
         done <= 1'b0;
         if (start && !active) begin
            active <= 1'b1;
            bit_cnt <= 3'h0;
            shreg <= tx_byte;
            pins.mosi <= tx_byte[7];
         end else if (active && tick) begin
            if (!pins.sck) begin
               if (pause) begin
                  pins.hold_n <= 1'b0;
               end else if (!pins.hold_n) begin
                  pins.hold_n <= 1'b1;
               end else begin
                  pins.sck <= 1'b1;
               end
            end else begin
               pins.sck <= 1'b0;
               rx_byte <= {rx_byte[6:0], miso_sync};
               if (bit_cnt == 3'h7) begin
                  active <= 1'b0;
                  done <= 1'b1;
               end else begin
                  bit_cnt <= bit_cnt + 3'h1;
                  shreg <= {shreg[6:0], 1'b0};
                  pins.mosi <= shreg[6];
               end
            end
         end
      end
   end

endmodule : sec_spi_shift

/* File: hw/sec_tick_div.sv */
`timescale 1ns/1ps
`include "sec_regs.svh"

module sec_tick_div
   import sec_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   output logic tick
);

   logic [3:0] cnt;

   // ==========================================================
   // half-period enable for the serial clock
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt <= 4'h0;
         tick <= 1'b0;
      end else if (cnt == 4'(`SEC_SCK_HALF_CYC - 1)) begin
         cnt <= 4'h0;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 4'h1;
         tick <= 1'b0;
      end
   end

endmodule : sec_tick_div

/* File: verification/sec_eeprom_model.sv */
`timescale 1ns/1ps

module sec_eeprom_model #(
   parameter int BUSY_NS = 3000
) (
   input wire logic cs_n,
   input wire logic sck,
   input wire logic mosi,
   input wire logic hold_n,
   input wire logic wp_n,
   output logic miso
);
   logic [7:0] mem [0:511];
   logic [7:0] sh;
   logic [7:0] op;
   logic [7:0] outb;
   logic [8:0] adr;
   logic [1:0] bp;
   logic write_enable_flag, busy, dead, abort, drv;
   int nbit;
   int nbyte;
   logic [16:0] wq [$];
   initial begin
      for (int i = 0; i < 512; i++) mem[i] = 8'(i) ^ 8'hA5;
      write_enable_flag = 1'b0;
      busy = 1'b0;
      bp = 2'b00;
      miso = 1'b0;
      dead = 1'b1;
   end
   function automatic logic prot(input logic [8:0] a);
      return bp == 2'b11 || (bp == 2'b10 && a[8]) || (bp == 2'b01 && a[8:7] == 2'b11);
   endfunction : prot
   always @(negedge cs_n) begin
      nbit = 0;
      nbyte = 0;
      dead = 1'b0;
      abort = 1'b0;
      drv = 1'b0;
      wq.delete();
   end
   always @(negedge wp_n) begin
      write_enable_flag = 1'b0;
      abort = !cs_n;
   end
   always @(posedge sck) begin
      if (!cs_n && hold_n && !dead) begin
         sh = {sh[6:0], mosi};
         nbit = (nbit + 1) % 8;
         if (nbit == 0) begin
            nbyte++;
            if (nbyte == 1) begin
               op = sh;
               dead = (busy && sh != 8'h05) || !(sh inside {8'h06, 8'h04, 8'h05, 8'h01}
                  || (sh[7:4] == 4'h0 && sh[2:1] == 2'b01));
               drv = sh == 8'h05;
            end else if (op[2:0] == 3'b011) begin
               adr = (nbyte == 2) ? {op[3], sh} : adr + 9'h001;
               drv = 1'b1;
            end else if (op[2:0] == 3'b010) begin
               // low address bits wrap in page
               if (nbyte > 2) wq.push_back({adr, sh});
               adr = (nbyte == 2) ? {op[3], sh} : {adr[8:4], adr[3:0] + 4'h1};
            end else if (op == 8'h01 && nbyte == 2) begin
               wq.push_back({9'h000, sh});
            end
            outb = (op == 8'h05) ? {4'hF, bp, write_enable_flag, busy} : mem[adr];
         end
      end
   end
   // output on fall, floating line flips
   always @(negedge sck or posedge cs_n or hold_n) begin
      miso <= (!cs_n && hold_n && drv && !dead) ? outb[7 - nbit] : ~miso;
   end
   always @(posedge cs_n) begin
      if (!dead && !abort && nbit == 0) begin
         if (op == 8'h06 && nbyte == 1 && wp_n) write_enable_flag = 1'b1;
         if (op == 8'h04 && nbyte == 1) write_enable_flag = 1'b0;
         if (write_enable_flag && wq.size() > 0 && (op == 8'h01 || op[2:0] == 3'b010)) fork
            write_cycle();
         join_none
      end
   end
   task automatic write_cycle();
      logic st;
      logic [16:0] q [$];
      st = op == 8'h01;
      q = wq;
      busy = 1'b1;
      #(BUSY_NS);
      foreach (q[i]) begin
         if (st) bp = q[i][3:2];
         else if (!prot(q[i][16:8])) mem[q[i][16:8]] = q[i][7:0];
      end
      write_enable_flag = 1'b0;
      busy = 1'b0;
   endtask : write_cycle
endmodule : sec_eeprom_model

/* File: verification/sec_host_asserts.sv */
`timescale 1ns/1ps
`include "sec_regs.svh"

module sec_host_asserts (
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic spi_cs_n,
   input wire logic spi_sck,
   input wire logic spi_mosi,
   input wire logic spi_hold_n,
   input wire logic spi_wp_n,
   input wire logic spi_miso
);
   logic sck_q;
   logic [7:0] nrise;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ====
   // rises counted per frame, cleared while deselected: poll frames sit one cycle apart
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sck_q <= 1'b0;
         nrise <= 8'h00;
      end else begin
         sck_q <= spi_sck;
         nrise <= spi_cs_n ? 8'h00 : nrise + 8'(spi_sck && !sck_q);
      end
   end
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one cycle");
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_sck_idle: assert property (spi_cs_n |-> !spi_sck)
      else $error("serial clock high while deselected");
   a_mosi_edge: assert property ($changed(spi_mosi) |-> !spi_sck)
      else $error("data out changed while serial clock high");
   a_sck_half: assert property ($rose(spi_sck) |=> spi_sck)
      else $error("serial clock high phase too short");
   a_hold_low: assert property ($changed(spi_hold_n) |-> !spi_sck)
      else $error("pause pin moved while serial clock high");
   a_hold_idle: assert property (spi_cs_n |-> spi_hold_n)
      else $error("pause pin low outside a frame");
   a_cs_setup: assert property ($fell(spi_cs_n) |-> (!spi_sck) [*2])
      else $error("serial clock rose too soon after select");
   a_frame_bytes: assert property ($rose(spi_cs_n) |-> nrise != 8'h00 && nrise[2:0] == 3'h0)
      else $error("frame not whole bytes");
   a_wp_follow: assert property (avs_write && !avs_waitrequest && avs_address == `SEC_OFS_PINS
      |=> spi_wp_n == !$past(avs_writedata[0]))
      else $error("inhibit pin does not follow register");
   c_pause: cover property ($fell(spi_hold_n));
   c_inhibit: cover property ($fell(spi_wp_n));
   c_status_frame: cover property ($rose(spi_cs_n) && nrise == 8'h10);
endmodule : sec_host_asserts

bind sec_host sec_host_asserts sec_host_asserts_inst (.clock(clock), .rst(rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
   .spi_mosi(spi_mosi), .spi_hold_n(spi_hold_n), .spi_wp_n(spi_wp_n), .spi_miso(spi_miso));

/* File: verification/tb_sec_host.sv */
`timescale 1ns/1ps
`include "sec_regs.svh"

module tb_sec_host;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic spi_cs_n, spi_sck, spi_mosi, spi_hold_n, spi_wp_n, spi_miso;
   logic [7:0] ref_mem [0:511];
   logic [31:0] rd;
   logic [8:0] a;
   logic [7:0] d;
   int fail_count = 0;
   int checked = 0;
   int n;
   bit pz = 1'b0;

   always #50 clock = ~clock;

   sec_host sec_host_inst (.clock(clock), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .spi_cs_n(spi_cs_n),
      .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_hold_n(spi_hold_n), .spi_wp_n(spi_wp_n),
      .spi_miso(spi_miso));
   sec_eeprom_model sec_eeprom_model_inst (.cs_n(spi_cs_n), .sck(spi_sck), .mosi(spi_mosi),
      .hold_n(spi_hold_n), .wp_n(spi_wp_n), .miso(spi_miso));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic complete_run();
      $display("checked %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run

   task automatic bus(input bit wr, input logic [7:0] ad, input logic [31:0] wd);
      int k;
      @(posedge clock);
      avs_address <= ad;
      avs_writedata <= wd;
      avs_read <= !wr;
      avs_write <= wr;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 20);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (k == 20) begin
         chk("waitrequest", 32'h0, 32'h1);
         complete_run();
      end
   endtask : bus

   // ====
   // command launch and poll; with pz set the pause is released mid-frame
   task automatic run(input logic [2:0] code);
      int k;
      bus(1'b1, `SEC_OFS_CMD, {29'h0, code});
      for (k = 0; k < 500; k++) begin
         if (pz && k == 20) begin
            chk("paused", 32'h0, {31'h0, spi_hold_n});
            bus(1'b1, `SEC_OFS_CMD, 32'h0000_0000);
            bus(1'b1, `SEC_OFS_PINS, 32'h0000_0000);
         end
         bus(1'b0, `SEC_OFS_STAT, 32'h0000_0000);
         if (rd[0] === 1'b0) break;
      end
      if (k == 500) begin
         chk("running", 32'h0, 32'h1);
         complete_run();
      end
   endtask : run

   task automatic stat_is(input logic [7:0] exp);
      run(3'h2);
      chk("status", {16'h0, exp, 8'h00}, rd & 32'h0000_FF01);
   endtask : stat_is

   task automatic check_read(input logic [8:0] ad, input int cnt);
      bus(1'b1, `SEC_OFS_ADDR, {23'h0, ad});
      bus(1'b1, `SEC_OFS_COUNT, cnt);
      run(3'h4);
      for (int i = 0; i < cnt; i++) begin
         bus(1'b0, 8'(64 + 4 * i), 32'h0);
         chk("array byte", {24'h0, ref_mem[9'(ad + i)]}, rd);
      end
   endtask : check_read

   initial begin
      n = $urandom(18892);
      for (int i = 0; i < 512; i++) ref_mem[i] = 8'(i) ^ 8'hA5;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      chk("pins", 32'h7, {29'h0, spi_cs_n, spi_hold_n, spi_wp_n});
      bus(1'b0, `SEC_OFS_COUNT, 32'h0);
      chk("count", 32'h1, rd);
      bus(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h0, rd);
      stat_is(8'hF0);
      $display("test power-up done");
      check_read(9'h1FE, $urandom_range(16, 3));
      a = 9'($urandom);
      bus(1'b1, `SEC_OFS_DATA_LO, {24'h0, ~ref_mem[a]});
      bus(1'b1, `SEC_OFS_COUNT, 32'h1);
      bus(1'b1, `SEC_OFS_ADDR, {23'h0, a});
      run(3'h5);
      check_read(a, 1);
      $display("test read and unlatched write done");
      run(3'h0);
      stat_is(8'hF2);
      run(3'h1);
      stat_is(8'hF0);
      $display("test latch done");
      // page write wraps in its page
      a = {5'($urandom), 4'hE};
      n = $urandom_range(16, 3);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         bus(1'b1, 8'(64 + 4 * i), {24'h0, d});
         ref_mem[{a[8:4], 4'(a[3:0] + i)}] = d;
      end
      bus(1'b1, `SEC_OFS_ADDR, {23'h0, a});
      bus(1'b1, `SEC_OFS_COUNT, n);
      run(3'h0);
      run(3'h5);
      stat_is(8'hF0);
      check_read({a[8:4], 4'h0}, 16);
      $display("test page write done");
      for (int p = 1; p < 5; p++) begin
         run(3'h0);
         bus(1'b1, `SEC_OFS_DATA_LO, {24'h0, 4'($urandom), 2'(p), 2'($urandom)});
         run(3'h3);
         stat_is({4'hF, 2'(p), 2'b00});
         run(3'h0);
         bus(1'b1, `SEC_OFS_ADDR, 32'h0000_01F0);
         bus(1'b1, `SEC_OFS_COUNT, 32'h1);
         bus(1'b1, `SEC_OFS_DATA_LO, {24'h0, ~ref_mem[9'h1F0]});
         run(3'h5);
         chk("refused", {31'h0, p < 4}, {31'h0, rd[2]});
         if (p == 4) ref_mem[9'h1F0] = ~ref_mem[9'h1F0];
         bus(1'b1, `SEC_OFS_STAT, 32'h0000_0004);
         check_read(9'h1F0, 1);
      end
      $display("test protect done");
      bus(1'b1, `SEC_OFS_PINS, 32'h0000_0001);
      @(negedge clock);
      chk("inhibit", 32'h0, {31'h0, spi_wp_n});
      run(3'h0);
      stat_is(8'hF0);
      bus(1'b1, `SEC_OFS_PINS, 32'h0000_0000);
      $display("test inhibit done");
      // paused read resumes; command while busy refused
      bus(1'b1, `SEC_OFS_PINS, 32'h0000_0002);
      pz = 1'b1;
      check_read(9'($urandom), 4);
      pz = 1'b0;
      bus(1'b0, `SEC_OFS_STAT, 32'h0);
      chk("busy refused", 32'h4, rd & 32'h0000_0004);
      bus(1'b1, `SEC_OFS_STAT, 32'h0000_0004);
      bus(1'b1, `SEC_OFS_CMD, 32'h0000_0007);
      bus(1'b0, `SEC_OFS_STAT, 32'h0);
      chk("bad code", 32'h4, rd & 32'h0000_0005);
      $display("test pause and refusal done");
      complete_run();
   end
endmodule : tb_sec_host
